// [lin_sbc_pkg.sv]
package lin_sbc_pkg;

    // Clock and common time base
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES    =
        (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Re-arm qualification: strictly longer than the figure, so one more tick
    localparam int REARM_US    = 10;
    localparam int REARM_TICKS = REARM_US + 1;

    // Dominant timeout on the transmit input
    localparam int DOM_TIMEOUT_MS    = 20;
    localparam int DOM_TIMEOUT_TICKS = DOM_TIMEOUT_MS * 1000 + 1;

    // Reset output hold after the regulated supply is back (least time)
    localparam int RESET_HOLD_MS    = 4;
    localparam int RESET_HOLD_TICKS = RESET_HOLD_MS * 1000 + 1;

    // Reset output fall delay and high-side overload debounce
    localparam int RESET_FALL_US       = 10;
    localparam int RESET_FALL_TICKS    = RESET_FALL_US;
    localparam int HS_DEBOUNCE_US      = 10;
    localparam int HS_DEBOUNCE_TICKS   = HS_DEBOUNCE_US;

    // Operating modes, one-hot
    typedef enum logic [3:0] {
        MODE_FAILSAFE = 4'h1,
        MODE_NORMAL   = 4'h2,
        MODE_SILENT   = 4'h4,
        MODE_SLEEP    = 4'h8
    } opMode_e;

    localparam opMode_e MODE_RESET = MODE_FAILSAFE;

    // Fail-safe source as shown on transmit and receive pins
    typedef struct packed {
        logic txdLevel;
        logic rxdLevel;
    } fsCode_s;

    localparam fsCode_s FS_BUS_WAKE   = '{txdLevel: 1'h0, rxdLevel: 1'h0};
    localparam fsCode_s FS_LOCAL_WAKE = '{txdLevel: 1'h0, rxdLevel: 1'h1};
    localparam fsCode_s FS_BATT_LOW   = '{txdLevel: 1'h1, rxdLevel: 1'h0};
    localparam fsCode_s FS_RESET      = FS_BATT_LOW;

endpackage

// [level_qualifier.sv]
`timescale 1ns/1ps

// Counts ticks while a level holds; restarts whenever the level drops.
module level_qualifier
#(
    parameter int LIMIT = 10
)
(
    input  wire logic sys_clk,
    input  wire logic rstN,
    input  wire logic tick,
    input  wire logic level,
    output logic      done
);
    localparam int W = $clog2(LIMIT + 1);

    logic [W-1:0] count;
    logic         atLimit;

    assign atLimit = (count == W'(LIMIT));
    // Done only while the level is still present
    assign done = level & atLimit;

    // Saturating count, cleared on each drop of the level
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
            count <= '0;
        else if (!level)
            count <= '0;
        else if (tick && !atLimit)
            count <= count + 1'h1;
    end
endmodule

// [lin_sbc_pin_control.sv]
// Behaviour
// [RQ1] Reset output goes low a fixed delay after undervoltage, stays low.
// [RQ2] Reset output stays low 4 ms after the supply is nominal again.
// [RQ3] Transmit low in normal mode drives bus dominant; high is recessive.
// [RQ4] Transmit low at normal entry blocks the driver until high over 10 us.
// [RQ5] Transmit low beyond 20 ms forces the bus driver recessive.
// [RQ6] After timeout the driver re-arms only after transmit high over 10 us.
// [RQ7] Sleep accepted with transmit stuck low; decision uses actual pin.
// [RQ8] In fail-safe the transmit pin becomes an output showing the cause.
// [RQ9] Wake output inverts wake input; wake from sleep/silent to fail-safe.
// [RQ10] Wake output follows wake input continuously in the awake modes.
// [RQ11] Both low-side outputs stay off outside normal mode.
// [RQ12] Low-side control low at normal entry blocks it until high over 10 us.
// [RQ13] Low-side on needs control high, normal, select high, no undervoltage.
// [RQ14] Low-side overload shutdown latches until control input goes low.
// [RQ15] Low-side short monitor blanked until transistor is fully on.
// [RQ16] High-side follows its control input in every mode except sleep.
// [RQ17] High-side overload is debounced and latched until control goes low.
// [RQ18] Bus driver off during overtemperature, back on after hysteresis.
// [RQ19] Bus short to ground does not block sleep; bus wake afterwards.
// [RQ20] Battery undervoltage stops transmission; power-up in fail-safe.
// [RQ21] Fail-safe cause coded on transmit and receive pins.
// [RQ22] Select falling: silent with transmit high, sleep with transmit low.
// [RQ23] Receive mirrors bus in normal mode and is high in silent mode.
// [RQ24] All qualification times share one restartable tick time base; the tick counter here runs free from reset.
`timescale 1ns/1ps

module lin_sbc_pin_control
#(
    parameter int TICK_CYCLES       = lin_sbc_pkg::TICK_CYCLES,
    parameter int DOM_TIMEOUT_TICKS = lin_sbc_pkg::DOM_TIMEOUT_TICKS,
    parameter int RESET_HOLD_TICKS  = lin_sbc_pkg::RESET_HOLD_TICKS
)
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic modeSelect,
    input  wire logic txdIn,
    output logic      txdOut,
    output logic      txdOeN,
    output logic      rxdOut,
    input  wire logic linRx,
    output logic      linDominant,
    input  wire logic busWake,
    input  wire logic linOvertemp,
    input  wire logic batterySupplyLow,
    input  wire logic vccUndervolt,
    output logic      regulatorEnable,
    output logic      undervoltageResetOut,
    output logic      undervoltageResetOeN,
    input  wire logic localWakeIn,
    output logic      wakeIndicatorOut,
    input  wire logic lowSideACtrl,
    input  wire logic lowSideBCtrl,
    input  wire logic [1:0] lowSideOverload,
    input  wire logic [1:0] lowSideFullOn,
    output logic      lowSideADrive,
    output logic      lowSideBDrive,
    input  wire logic highSideCtrl,
    input  wire logic highSideOverload,
    output logic      highSideDrive
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    logic [1:0]          rstSync;
    logic                rstN;
    logic [TICK_W-1:0]   tickCount;
    logic                tick;
    lin_sbc_pkg::opMode_e mode;
    lin_sbc_pkg::opMode_e next_mode;
    lin_sbc_pkg::fsCode_s cause;
    lin_sbc_pkg::fsCode_s next_cause;
    logic                isNormal;
    logic                isFailsafe;
    logic                isSilent;
    logic                isSleep;
    logic                enPrev;
    logic                lowPowerReq;
    logic                enterNormal;
    logic                resetHeld;
    logic                vccBadDone;
    logic                vccGoodDone;
    logic                txdHighDone;
    logic                txdLowLevel;
    logic                txdLowDone;
    logic                txdArmed;
    logic [1:0]          lsCtrl;
    logic [1:0]          lsHighDone;
    logic [1:0]          lsArmed;
    logic [1:0]          lsLatched;
    logic [1:0]          lsMonitor;
    logic [1:0]          lsDrive;
    logic [1:0]          next_lsDrive;
    logic                hsOvlLevel;
    logic                hsOvlDone;
    logic                hsLatched;
    logic                next_hsDrive;
    logic                next_linDominant;
    logic                next_rxd;
    logic                causeTxd;
    logic                causeRxd;

    // Reset release through two flops; only the second one is read
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'h1};
    end
    assign rstN = rstSync[1];

    // [RQ24] shared tick base
    // One microsecond tick feeds every qualifier, so all times agree
    assign tick = (tickCount == TICK_W'(TICK_CYCLES - 1));
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
            tickCount <= '0;
        else
            tickCount <= tick ? '0 : tickCount + 1'h1;
    end

    // Mode decode
    assign isNormal    = (mode == lin_sbc_pkg::MODE_NORMAL);
    assign isFailsafe  = (mode == lin_sbc_pkg::MODE_FAILSAFE);
    assign isSilent    = (mode == lin_sbc_pkg::MODE_SILENT);
    assign isSleep     = (mode == lin_sbc_pkg::MODE_SLEEP);
    assign causeTxd    = cause.txdLevel;
    assign causeRxd    = cause.rxdLevel;
    assign lsCtrl      = {lowSideBCtrl, lowSideACtrl};
    // No low-power request while the reset output is held
    assign lowPowerReq = enPrev & ~modeSelect & (isNormal | isFailsafe)
                         & ~resetHeld;
    assign enterNormal = (next_mode == lin_sbc_pkg::MODE_NORMAL) & ~isNormal;

    // [RQ1] reset fall delay
    level_qualifier #(.LIMIT(lin_sbc_pkg::RESET_FALL_TICKS)) vccBadQual
    (
        .sys_clk (sys_clk),
        .rstN    (rstN),
        .tick    (tick),
        .level   (vccUndervolt),
        .done    (vccBadDone)
    );

    // [RQ2] reset hold time
    level_qualifier #(.LIMIT(RESET_HOLD_TICKS)) vccGoodQual
    (
        .sys_clk (sys_clk),
        .rstN    (rstN),
        .tick    (tick),
        .level   (~vccUndervolt),
        .done    (vccGoodDone)
    );

    // [RQ4] transmit high qualification
    level_qualifier #(.LIMIT(lin_sbc_pkg::REARM_TICKS)) txdHighQual
    (
        .sys_clk (sys_clk),
        .rstN    (rstN),
        .tick    (tick),
        .level   (txdIn),
        .done    (txdHighDone)
    );

    // [RQ5] dominant timeout counts only in normal mode
    assign txdLowLevel = isNormal & ~txdIn;
    level_qualifier #(.LIMIT(DOM_TIMEOUT_TICKS)) txdLowQual
    (
        .sys_clk (sys_clk),
        .rstN    (rstN),
        .tick    (tick),
        .level   (txdLowLevel),
        .done    (txdLowDone)
    );

    // [RQ17] high-side overload debounce
    assign hsOvlLevel = highSideOverload & highSideDrive;
    level_qualifier #(.LIMIT(lin_sbc_pkg::HS_DEBOUNCE_TICKS)) hsOvlQual
    (
        .sys_clk (sys_clk),
        .rstN    (rstN),
        .tick    (tick),
        .level   (hsOvlLevel),
        .done    (hsOvlDone)
    );

    // Reset output holder; held from power-up until the supply qualifies
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
            resetHeld <= 1'h1;
        else
            resetHeld <= vccBadDone | (resetHeld & ~vccGoodDone);
    end

    // Mode sequencer; wake sources only act from the low-power modes
    always_comb
    begin
        next_mode  = mode;
        next_cause = cause;
        unique case (mode)
            lin_sbc_pkg::MODE_FAILSAFE:
            begin
                // [RQ22] select low picks silent or sleep
                if (lowPowerReq)
                    next_mode = txdIn ? lin_sbc_pkg::MODE_SILENT
                                      : lin_sbc_pkg::MODE_SLEEP;
                else if (modeSelect && !batterySupplyLow && !resetHeld)
                    next_mode = lin_sbc_pkg::MODE_NORMAL;
            end
            lin_sbc_pkg::MODE_NORMAL:
            begin
                // [RQ7] sleep decided on the actual pin level
                if (lowPowerReq)
                    next_mode = txdIn ? lin_sbc_pkg::MODE_SILENT
                                      : lin_sbc_pkg::MODE_SLEEP;
                else if (batterySupplyLow)
                begin
                    next_mode  = lin_sbc_pkg::MODE_FAILSAFE;
                    next_cause = lin_sbc_pkg::FS_BATT_LOW;
                end
                else if (resetHeld)
                    next_mode = lin_sbc_pkg::MODE_FAILSAFE;
            end
            lin_sbc_pkg::MODE_SILENT, lin_sbc_pkg::MODE_SLEEP:
            begin
                // [RQ19] bus wake after a released short
                if (busWake)
                begin
                    next_mode  = lin_sbc_pkg::MODE_FAILSAFE;
                    next_cause = lin_sbc_pkg::FS_BUS_WAKE;
                end
                // [RQ9] local wake into fail-safe
                else if (!localWakeIn)
                begin
                    next_mode  = lin_sbc_pkg::MODE_FAILSAFE;
                    next_cause = lin_sbc_pkg::FS_LOCAL_WAKE;
                end
                else if (isSilent && resetHeld)
                    next_mode = lin_sbc_pkg::MODE_FAILSAFE;
            end
            default:
                next_mode = lin_sbc_pkg::MODE_FAILSAFE;
        endcase
    end

    // [RQ20] power-up in fail-safe
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            mode   <= lin_sbc_pkg::MODE_RESET;
            cause  <= lin_sbc_pkg::FS_RESET;
            enPrev <= 1'h0;
        end
        else
        begin
            mode   <= next_mode;
            cause  <= next_cause;
            enPrev <= modeSelect;
        end
    end

    // [RQ6] transmit arming
    // Disarmed by timeout, re-armed by a qualified high level
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
            txdArmed <= 1'h0;
        else if (enterNormal)
            txdArmed <= txdIn;
        else if (txdLowDone)
            txdArmed <= 1'h0;
        else if (txdHighDone)
            txdArmed <= 1'h1;
    end

    // Low-side channels share one structure
    for (genvar i = 0; i < 2; i++)
    begin : lowSide
        // [RQ12] control high qualification
        level_qualifier #(.LIMIT(lin_sbc_pkg::REARM_TICKS)) highQual
        (
            .sys_clk (sys_clk),
            .rstN    (rstN),
            .tick    (tick),
            .level   (lsCtrl[i]),
            .done    (lsHighDone[i])
        );

        // [RQ15] monitor blanked during switch-on
        assign lsMonitor[i] = lsDrive[i] & lowSideFullOn[i];

        // [RQ11] normal mode only
        // [RQ13] switch-on conditions
        assign next_lsDrive[i] = isNormal & modeSelect & ~batterySupplyLow
                                 & lsCtrl[i] & lsArmed[i] & ~lsLatched[i];

        // [RQ12] arming at entry and on a qualified high
        always_ff @(posedge sys_clk or negedge rstN)
        begin
            if (!rstN)
                lsArmed[i] <= 1'h0;
            else if (enterNormal)
                lsArmed[i] <= lsCtrl[i];
            else if (lsHighDone[i])
                lsArmed[i] <= 1'h1;
        end

        // [RQ14] overload latch, a new overload wins over the clear
        always_ff @(posedge sys_clk or negedge rstN)
        begin
            if (!rstN)
                lsLatched[i] <= 1'h0;
            else
                lsLatched[i] <= (lowSideOverload[i] & lsMonitor[i])
                                | (lsLatched[i] & lsCtrl[i]);
        end
    end

    // [RQ17] high-side latch, set wins over the clear
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
            hsLatched <= 1'h0;
        else
            hsLatched <= hsOvlDone | (hsLatched & highSideCtrl);
    end

    // [RQ16] high-side gating
    assign next_hsDrive = ~isSleep & highSideCtrl & ~hsLatched;

    // [RQ3] bus driver gating
    // [RQ18] overtemperature cut-off
    // Timeout, undervoltage and overtemperature all force recessive
    assign next_linDominant = isNormal & txdArmed & ~txdIn & ~txdLowDone
                              & ~batterySupplyLow & ~linOvertemp;

    // [RQ23] receive selection
    assign next_rxd = isNormal   ? linRx :
                      isFailsafe ? causeRxd : 1'h1;

    // Driver outputs; one cycle of latency, glitch-free toward the loads
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            linDominant   <= 1'h0;
            lsDrive       <= 2'h0;
            highSideDrive <= 1'h0;
        end
        else
        begin
            linDominant   <= next_linDominant;
            lsDrive       <= next_lsDrive;
            highSideDrive <= next_hsDrive;
        end
    end
    assign lowSideADrive = lsDrive[0];
    assign lowSideBDrive = lsDrive[1];

    // [RQ8] transmit pin turned output in fail-safe
    // [RQ9] [RQ10] wake output mirror
    // [RQ21] cause on pins
    // Pins toward the host; reset output is open drain, pulled low only
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            txdOut               <= 1'h1;
            txdOeN               <= 1'h1;
            rxdOut               <= 1'h1;
            wakeIndicatorOut     <= 1'h0;
            regulatorEnable      <= 1'h1;
            undervoltageResetOeN <= 1'h0;
        end
        else
        begin
            txdOut               <= causeTxd;
            txdOeN               <= ~isFailsafe;
            rxdOut               <= next_rxd;
            wakeIndicatorOut     <= ~localWakeIn;
            regulatorEnable      <= ~isSleep;
            undervoltageResetOeN <= ~resetHeld;
        end
    end
    assign undervoltageResetOut = 1'h0;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstN);

    resetAssert_a: assert property ( // [RQ1]
        $fell(undervoltageResetOeN) |-> $past(vccBadDone, 2))
        else $error("Reset output fell without qualified undervoltage");
    resetRelease_a: assert property ( // [RQ2]
        $rose(undervoltageResetOeN) |-> $past(vccGoodDone, 2))
        else $error("Reset output released before hold time");
    txdGate_a: assert property ( // [RQ3]
        linDominant |-> $past(isNormal) && !$past(txdIn))
        else $error("Bus dominant without low transmit in normal mode");
    entryBlock_a: assert property ( // [RQ4]
        (enterNormal && !txdIn) |=> !txdArmed [*2])
        else $error("Driver armed right after entry with transmit low");
    domTimeout_a: assert property ( // [RQ5]
        txdLowDone |=> !linDominant)
        else $error("Bus still dominant after timeout");
    rearm_a: assert property ( // [RQ6]
        $rose(txdArmed) |-> $past(txdHighDone || (enterNormal && txdIn)))
        else $error("Driver re-armed without qualified high");
    sleepSelect_a: assert property ( // [RQ7]
        (lowPowerReq && !txdIn) |=> isSleep ##1 !regulatorEnable)
        else $error("Sleep request with transmit low not taken");
    silentSelect_a: assert property ( // [RQ22]
        (lowPowerReq && txdIn) |=> isSilent ##1 rxdOut)
        else $error("Silent request not taken");
    fsCode_a: assert property ( // [RQ21]
        ($past(isFailsafe) && $past(rstN)) |-> !txdOeN
            && txdOut == $past(causeTxd) && rxdOut == $past(causeRxd))
        else $error("Fail-safe cause not shown on pins");
    wakeEntry_a: assert property ( // [RQ9]
        ((isSleep || isSilent) && !localWakeIn) |=> isFailsafe)
        else $error("Local wake did not reach fail-safe");
    wakeMirror_a: assert property ( // [RQ10]
        $past(rstN) |-> wakeIndicatorOut == !$past(localWakeIn))
        else $error("Wake output does not follow wake input");
    lsMode_a: assert property ( // [RQ11]
        !$past(isNormal) |-> lsDrive == 2'h0)
        else $error("Low-side on outside normal mode");
    lsArm_a: assert property ( // [RQ12]
        $rose(lsArmed[0])
            |-> $past(lsHighDone[0] || (enterNormal && lsCtrl[0])))
        else $error("Low-side armed without qualified high");
    lsQualify_a: assert property ( // [RQ13]
        |lsDrive |-> $past(isNormal && modeSelect && !batterySupplyLow))
        else $error("Low-side on without its conditions");
    lsLatch_a: assert property ( // [RQ14]
        lsLatched[0] |=> !lsDrive[0])
        else $error("Low-side on while shutdown latched");
    lsBlank_a: assert property ( // [RQ15]
        $rose(lsLatched[0]) |-> $past(lowSideFullOn[0] && lsDrive[0]))
        else $error("Short trip during switch-on blanking");
    hsSleep_a: assert property ( // [RQ16]
        isSleep |=> !highSideDrive)
        else $error("High-side on in sleep");
    hsLatch_a: assert property ( // [RQ17]
        $fell(hsLatched) |-> !$past(highSideCtrl) && !$past(hsOvlDone))
        else $error("High-side latch cleared with control high");
    overtemp_a: assert property ( // [RQ18]
        linOvertemp |=> !linDominant)
        else $error("Bus driven during overtemperature");
    busWake_a: assert property ( // [RQ19]
        ((isSleep || isSilent) && busWake)
            |=> isFailsafe && !causeRxd && !causeTxd)
        else $error("Bus wake from low-power mode not signalled");
    battLow_a: assert property ( // [RQ20]
        batterySupplyLow |=> !linDominant && lsDrive == 2'h0)
        else $error("Transmission during battery undervoltage");
    rxdMirror_a: assert property ( // [RQ23]
        $past(isNormal) |-> rxdOut == $past(linRx))
        else $error("Receive does not mirror bus");

    normalEntry_c: cover property (enterNormal ##1 isNormal);
    domTimeout_c:  cover property ($rose(txdLowDone));
    lsTrip_c:      cover property ($rose(lsLatched[0]));
    sleepWake_c:   cover property (isSleep ##1 isFailsafe);
endmodule

// [host_model.sv]
`timescale 1ns/1ps

// Host side of the shared transmit pin and the open-drain reset pin
module host_model
(
    input  wire logic hostTxd,
    input  wire logic txdOut,
    input  wire logic txdOeN,
    input  wire logic undervoltageResetOut,
    input  wire logic undervoltageResetOeN,
    output logic      txdIn,
    output logic      resetPinN
);
    // host transmit level
    // Host turns its pin to input while the device reports the cause
    assign txdIn = txdOeN ? hostTxd : txdOut;
    // Pull-up wins whenever the device lets go of the reset pin
    assign resetPinN = undervoltageResetOeN ? 1'h1 : undervoltageResetOut;
endmodule

// [lin_sbc_pin_control_tb.sv]
`timescale 1ns/1ps

`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin numErrors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end

module lin_sbc_pin_control_tb;
    logic       sys_clk, resetn, modeSelect, hostTxd, txdIn, linRx, busWake;
    logic       linOvertemp, batterySupplyLow, vccUndervolt, localWakeIn;
    logic       lowSideACtrl, lowSideBCtrl, highSideCtrl, highSideOverload;
    logic [1:0] lowSideOverload, lowSideFullOn;
    logic       txdOut, txdOeN, rxdOut, linDominant, regulatorEnable;
    logic       undervoltageResetOut, undervoltageResetOeN, resetPinN;
    logic       wakeIndicatorOut, lowSideADrive, lowSideBDrive, highSideDrive;
    int         numErrors = 0;
    int         numChecks = 0;

    // Short counts: tick 4 cycles, timeout 120 cycles, hold 80 cycles
    lin_sbc_pin_control #(.TICK_CYCLES(4), .DOM_TIMEOUT_TICKS(30),
        .RESET_HOLD_TICKS(20)) dut_u (.sys_clk, .resetn, .modeSelect,
        .txdIn, .txdOut, .txdOeN, .rxdOut, .linRx, .linDominant, .busWake,
        .linOvertemp, .batterySupplyLow, .vccUndervolt, .regulatorEnable,
        .undervoltageResetOut, .undervoltageResetOeN, .localWakeIn,
        .wakeIndicatorOut, .lowSideACtrl, .lowSideBCtrl, .lowSideOverload,
        .lowSideFullOn, .lowSideADrive, .lowSideBDrive, .highSideCtrl,
        .highSideOverload, .highSideDrive);

    host_model host_u (.hostTxd, .txdOut, .txdOeN, .undervoltageResetOut,
        .undervoltageResetOeN, .txdIn, .resetPinN);

    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // Inputs change 1 ns after the edge so sampling is never racy
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task stopTest;
        $display("checks=%0d errors=%0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task powerUp;
        cyc(40);
        `CHK(resetPinN, 1'h0)
        cyc(60);
        `CHK(resetPinN, 1'h1)
        `CHK({txdOeN, txdOut, rxdOut, regulatorEnable}, 4'h5)
        modeSelect = 1'h1;
        cyc(3);
        `CHK({txdOeN, lowSideADrive, lowSideBDrive}, 3'h6)
    endtask

    task lowSide;
        lowSideBCtrl = 1'h1;
        cyc(20);
        `CHK(lowSideBDrive, 1'h0)
        cyc(40);
        `CHK(lowSideBDrive, 1'h1)
        lowSideOverload = 2'h1;
        cyc(5);
        `CHK(lowSideADrive, 1'h1)
        lowSideFullOn = 2'h1;
        cyc(3);
        lowSideOverload = 2'h0;
        cyc(3);
        `CHK(lowSideADrive, 1'h0)
        lowSideACtrl = 1'h0;
        cyc(2);
        lowSideACtrl = 1'h1;
        cyc(3);
        `CHK(lowSideADrive, 1'h1)
    endtask

    task highSide;
        highSideOverload = 1'h1;
        cyc(20);
        highSideOverload = 1'h0;
        cyc(2);
        `CHK(highSideDrive, 1'h1)
        highSideOverload = 1'h1;
        cyc(55);
        highSideOverload = 1'h0;
        cyc(2);
        `CHK(highSideDrive, 1'h0)
        highSideCtrl = 1'h0;
        cyc(2);
        highSideCtrl = 1'h1;
        cyc(3);
        `CHK(highSideDrive, 1'h1)
    endtask

    task heatAndBattery;
        hostTxd = 1'h0;
        cyc(3);
        linOvertemp = 1'h1;
        cyc(3);
        `CHK({linDominant, rxdOut}, 2'h1)
        linOvertemp = 1'h0;
        cyc(3);
        `CHK(linDominant, 1'h1)
        hostTxd = 1'h1;
        batterySupplyLow = 1'h1;
        cyc(3);
        `CHK({txdOeN, linDominant}, 2'h0)
        `CHK({lowSideADrive, lowSideBDrive}, 2'h0)
        `CHK({txdOut, rxdOut}, 2'h2)
        batterySupplyLow = 1'h0;
        cyc(3);
        `CHK({txdOeN, lowSideADrive}, 2'h3)
    endtask

    task timeoutSleep;
        hostTxd = 1'h0;
        linRx = 1'h0;
        cyc(3);
        `CHK({linDominant, rxdOut}, 2'h2)
        cyc(130);
        `CHK(linDominant, 1'h0)
        modeSelect = 1'h0;
        cyc(3);
        `CHK({regulatorEnable, highSideDrive, lowSideADrive}, 3'h0)
        localWakeIn = 1'h0;
        cyc(3);
        `CHK({wakeIndicatorOut, txdOeN, txdOut, rxdOut}, 4'h9)
        `CHK({regulatorEnable, highSideDrive, lowSideADrive}, 3'h6)
        localWakeIn = 1'h1;
        linRx = 1'h1;
        cyc(2);
        `CHK(wakeIndicatorOut, 1'h0)
    endtask

    task rearm;
        modeSelect = 1'h1;
        cyc(23);
        `CHK({txdOeN, linDominant}, 2'h2)
        hostTxd = 1'h1;
        cyc(20);
        hostTxd = 1'h0;
        cyc(3);
        `CHK(linDominant, 1'h0)
        hostTxd = 1'h1;
        cyc(60);
        hostTxd = 1'h0;
        cyc(3);
        `CHK(linDominant, 1'h1)
        hostTxd = 1'h1;
        cyc(2);
    endtask

    task silentWake;
        linRx = 1'h0;
        modeSelect = 1'h0;
        cyc(3);
        `CHK({regulatorEnable, rxdOut}, 2'h3)
        busWake = 1'h1;
        cyc(1);
        busWake = 1'h0;
        cyc(3);
        `CHK({txdOeN, txdOut, rxdOut}, 3'h0)
        linRx = 1'h1;
    endtask

    task underVolt;
        vccUndervolt = 1'h1;
        cyc(25);
        `CHK(resetPinN, 1'h1)
        cyc(30);
        vccUndervolt = 1'h0;
        cyc(60);
        `CHK(resetPinN, 1'h0)
        cyc(40);
        `CHK(resetPinN, 1'h1)
    endtask

    // Main sequence, all inputs set at time zero
    initial
    begin
        {sys_clk, resetn, modeSelect, busWake, linOvertemp} = 5'h0;
        {batterySupplyLow, vccUndervolt, highSideOverload} = 3'h0;
        {hostTxd, linRx, localWakeIn, highSideCtrl, lowSideACtrl} = 5'h1f;
        lowSideBCtrl = 1'h0;
        lowSideOverload = 2'h0;
        lowSideFullOn = 2'h0;
        cyc(10);
        resetn = 1'h1;
        powerUp();
        lowSide();
        highSide();
        heatAndBattery();
        timeoutSleep();
        rearm();
        silentWake();
        underVolt();
        stopTest();
    end

    // Whole run is under 1000 cycles; 20000 means a hang
    initial
    begin
        #200000;
        numErrors++;
        stopTest();
    end
endmodule
